// file: design/command_source_select.v
// selects one command bit out of the synchronised status inputs
`timescale 1ns/100ps
module command_source_select (
  input wire [5:0] status_bits,
  input wire [2:0] select,
  output wire chosen
);
  // ----------------------------------------
  // selection
  // ----------------------------------------
  // code 0 always off, 1 always on, 2..7 status bit 0..5
  wire [7:0] table_bits;
  assign table_bits = {status_bits, 1'b1, 1'b0};
  assign chosen = table_bits[select];
endmodule

// file: design/start_stop_direction_decoder.v
// start/stop/direction decoder for the second external control location
// How it works
// - control register field selects how the two sources give commands
// - mode 0: no input source, no start generated
// - mode 1: first source alone starts; direction never from inputs
// - mode 2: first source starts, second source gives direction
// - mode 2: first low stops; second low forward, high reverse
// - edge trigger qualifies on rising input, level trigger while high
// - mode 3: first source forward start, second reverse start
// - mode 3: both equal stops; one qualified with other low starts
// - mode 4: rising first source starts only while second high; low stops
// - mode 4: trigger setting ignored, start always on rising edge
// - mode 4: panel keys inhibited while second source low
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`include "start_stop_direction_decoder_consts.vh"
module start_stop_direction_decoder (
  input wire sys_clk,
  input wire reset_n,
  input wire [5:0] status_in,
  output reg run_cmd,
  output reg reverse_cmd,
  output reg start_pulse,
  output reg stop_pulse,
  output reg panel_keys_enable,
  input wire [3:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [5:0] meta_q;
  reg [5:0] sync_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= status_in;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [31:0] control_q;
  wire [3:0] location_command_mode;
  wire start_trigger_kind;
  wire [2:0] first_sel;
  wire [2:0] second_sel;
  assign location_command_mode = control_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
  assign start_trigger_kind = control_q[`CTL_TRIG_BIT];
  assign first_sel = control_q[`CTL_SRC1_MSB:`CTL_SRC1_LSB];
  assign second_sel = control_q[`CTL_SRC2_MSB:`CTL_SRC2_LSB];

  wire first_command_source;
  wire second_command_source;
  command_source_select sel_first (
    .status_bits(sync_q),
    .select(first_sel),
    .chosen(first_command_source)
  );
  command_source_select sel_second (
    .status_bits(sync_q),
    .select(second_sel),
    .chosen(second_command_source)
  );

  // ----------------------------------------
  // qualification
  // ----------------------------------------
  reg first_prev_q;
  reg second_prev_q;
  wire first_rise;
  wire second_rise;
  wire first_qual;
  wire second_qual;
  assign first_rise = first_command_source & ~first_prev_q;
  assign second_rise = second_command_source & ~second_prev_q;
  assign first_qual = (start_trigger_kind == `TRIG_EDGE) ? first_rise : first_command_source;
  assign second_qual = (start_trigger_kind == `TRIG_EDGE) ? second_rise : second_command_source;

  // edge memory resets low: a source already high at release reads as a rise
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_prev_q <= 1'b0;
      second_prev_q <= 1'b0;
    end else begin
      first_prev_q <= first_command_source;
      second_prev_q <= second_command_source;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  reg run_d;
  reg rev_d;
  always @* begin
    run_d = run_cmd;
    rev_d = reverse_cmd;
    case (location_command_mode)
      `MODE_SINGLE: begin
        rev_d = 1'b0;
        if (!first_command_source)
          run_d = 1'b0;
        else if (first_qual)
          run_d = 1'b1;
      end
      `MODE_START_DIR: begin
        // start from first, direction from second
        if (!first_command_source) begin
          run_d = 1'b0;
        end else if (first_qual) begin
          run_d = 1'b1;
          rev_d = second_command_source;
        end else if (run_cmd) begin
          rev_d = second_command_source;
        end
      end
      `MODE_FWD_REV: begin
        if (first_command_source == second_command_source) begin
          run_d = 1'b0;
        end else if (first_command_source) begin
          if (first_qual || (run_cmd && !reverse_cmd)) begin
            run_d = 1'b1;
            rev_d = 1'b0;
          end else begin
            run_d = 1'b0;
          end
        end else begin
          if (second_qual || (run_cmd && reverse_cmd)) begin
            run_d = 1'b1;
            rev_d = 1'b1;
          end else begin
            run_d = 1'b0;
          end
        end
      end
      `MODE_PULSE_STOP: begin
        // second low stops, rising first starts
        rev_d = 1'b0;
        if (!second_command_source)
          run_d = 1'b0;
        else if (first_rise)
          run_d = 1'b1;
      end
      default: begin
        run_d = 1'b0;
        rev_d = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_cmd <= 1'b0;
      reverse_cmd <= 1'b0;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      panel_keys_enable <= 1'b1;
    end else begin
      run_cmd <= run_d;
      reverse_cmd <= rev_d;
      start_pulse <= run_d & ~run_cmd;
      stop_pulse <= ~run_d & run_cmd;
      // panel keys off while second low in mode 4 only
      panel_keys_enable <= !((location_command_mode == `MODE_PULSE_STOP) && !second_command_source);
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // address and data latched separately, so either may arrive first
  reg aw_held_q;
  reg w_held_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire do_write;
  wire [31:0] status_word;
  wire [31:0] wmask;
  wire wr_control;
  wire wr_status;
  wire rd_control;
  wire rd_status;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  // byte lanes of the write strobe widened to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8+7:lane*8] = {8{wstrb_q[lane]}};
    end
  endgenerate

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // word index only; the two low address bits are ignored
  assign wr_control = ({awaddr_q[3:2], 2'b00} == `OFS_CONTROL);
  assign wr_status = ({awaddr_q[3:2], 2'b00} == `OFS_STATUS);
  assign rd_control = ({s_axi_araddr[3:2], 2'b00} == `OFS_CONTROL);
  assign rd_status = ({s_axi_araddr[3:2], 2'b00} == `OFS_STATUS);
  assign status_word = {26'h0000000, second_command_source, first_command_source, 1'b0,
                        ~panel_keys_enable, reverse_cmd, run_cmd};

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      control_q <= `CTL_RESET;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_control) begin
          control_q <= (control_q & ~wmask) | (wdata_q & wmask);
          s_axi_bresp <= `RESP_OKAY;
        end else if (wr_status) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (rd_control) begin
          s_axi_rdata <= control_q;
        end else if (rd_status) begin
          s_axi_rdata <= status_word;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: design/start_stop_direction_decoder_consts.vh
// constants for the start/stop/direction decoder of the second external location
`ifndef START_STOP_DIRECTION_DECODER_CONSTS_VH
`define START_STOP_DIRECTION_DECODER_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 3
`define CTL_TRIG_BIT 4
`define CTL_SRC1_LSB 8
`define CTL_SRC1_MSB 10
`define CTL_SRC2_LSB 12
`define CTL_SRC2_MSB 14
`define CTL_RESET 32'h0000_2010

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STS_RUN_BIT 0
`define STS_REV_BIT 1
`define STS_KEYS_BIT 2
`define STS_SRC1_BIT 4
`define STS_SRC2_BIT 5

// ----------------------------------------
// command modes and trigger kinds
// ----------------------------------------
`define MODE_NONE 4'h0
`define MODE_SINGLE 4'h1
`define MODE_START_DIR 4'h2
`define MODE_FWD_REV 4'h3
`define MODE_PULSE_STOP 4'h4
`define TRIG_EDGE 1'b0
`define TRIG_LEVEL 1'b1

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: tb/start_stop_direction_decoder_props.sv
// port assertions for the start/stop/direction decoder
`timescale 1ns/100ps
module decoder_props (
  input wire sys_clk,
  input wire reset_n,
  input wire run_cmd,
  input wire reverse_cmd,
  input wire start_pulse,
  input wire stop_pulse,
  input wire panel_keys_enable,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_start_rise: assert property (start_pulse |-> run_cmd && !$past(run_cmd))
    else $error("start pulse without run rising");
  chk_rise_pulse: assert property ($rose(run_cmd) |-> start_pulse)
    else $error("run rose without start pulse");
  chk_stop_fall: assert property ($fell(run_cmd) |-> stop_pulse && !start_pulse)
    else $error("run fell without stop pulse");
  chk_stop_once: assert property (stop_pulse |-> !run_cmd ##1 !stop_pulse)
    else $error("stop pulse malformed");
  chk_pulse_once: assert property (start_pulse |=> !start_pulse)
    else $error("start pulse longer than one cycle");
  chk_keys_stop: assert property (!panel_keys_enable |-> !run_cmd)
    else $error("running while panel keys inhibited");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read answer late");
  cov_rev_start: cover property (start_pulse && reverse_cmd);
  cov_stop: cover property (stop_pulse);
  cov_keys_off: cover property (!panel_keys_enable);
endmodule
bind start_stop_direction_decoder decoder_props u_props (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .run_cmd(run_cmd),
  .reverse_cmd(reverse_cmd),
  .start_pulse(start_pulse),
  .stop_pulse(stop_pulse),
  .panel_keys_enable(panel_keys_enable),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata)
);

// file: tb/start_stop_direction_decoder_tb.sv
// self-checking bench for the start/stop/direction decoder
`timescale 1ns/100ps
`include "start_stop_direction_decoder_consts.vh"
module start_stop_direction_decoder_tb;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [5:0] req = 6'h00;
  reg [3:0] awaddr = 4'h0;
  reg [3:0] araddr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hF;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire [5:0] status_in;
  wire run_cmd, reverse_cmd, start_pulse, stop_pulse, panel_keys_enable;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer errors = 0, check_count = 0, cycles = 0, i;
  reg [31:0] seed = 32'h51D7, d;
  reg [1:0] r, e;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  status_source src (.sys_clk(sys_clk), .level_req(req), .status_in(status_in));
  start_stop_direction_decoder dut (.sys_clk(sys_clk), .reset_n(reset_n), .status_in(status_in),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
    .panel_keys_enable(panel_keys_enable), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  initial forever #5 sys_clk = ~sys_clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // level trigger, forward/reverse mode: one side alone runs
  function [1:0] exp3(input a, input b);
    exp3 = {a ^ b, b & ~a};
  endfunction
  task chk(input [8*5:1] name, input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task axw(input [3:0] a, input [31:0] v);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (wready) bready <= 1'b1;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task axr(input [3:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (arready) rready <= 1'b1;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task cfg(input [3:0] m, input t);
    axw(`OFS_CONTROL, {16'h0000, 4'h3, 4'h2, 3'h0, t, m});
  endtask
  // first source on status bit 0, second on bit 1, other bits random noise
  task step(input a, input b, input er, input ev);
    @(posedge sys_clk);
    seed = xs(seed);
    req <= {seed[3:0], b, a};
    repeat (5) @(posedge sys_clk);
    chk("run", run_cmd, er);
    chk("rev", reverse_cmd & run_cmd, ev & er);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    axr(`OFS_CONTROL);
    chk("ctl", d, `CTL_RESET);
    axr(4'h8);
    chk("resp", r, `RESP_SLVERR);
    axw(`OFS_STATUS, 32'hFFFF_FFFF);
    chk("bresp", r, `RESP_OKAY);
    axw(4'hC, 32'hFFFF_FFFF);
    chk("bresp", r, `RESP_SLVERR);
    wstrb <= 4'h2;
    axw(`OFS_CONTROL, 32'hA5A5_5AA5);
    wstrb <= 4'hF;
    axr(`OFS_CONTROL);
    chk("lane", d, 32'h0000_5A10);
    // route the sources in mode 0 first, so the mode switch makes no false edge
    cfg(`MODE_NONE, `TRIG_LEVEL);
    step(1, 0, 0, 0);
    cfg(`MODE_SINGLE, `TRIG_EDGE);
    step(1, 1, 0, 0);
    cfg(`MODE_SINGLE, `TRIG_LEVEL);
    step(1, 1, 1, 0);
    step(0, 1, 0, 0);
    cfg(`MODE_SINGLE, `TRIG_EDGE);
    step(1, 0, 1, 0);
    step(0, 0, 0, 0);
    $display("single input start done");
    cfg(`MODE_START_DIR, `TRIG_EDGE);
    step(0, 1, 0, 0);
    step(1, 1, 1, 1);
    step(1, 0, 1, 0);
    step(0, 0, 0, 0);
    cfg(`MODE_FWD_REV, `TRIG_EDGE);
    step(1, 0, 1, 0);
    step(1, 1, 0, 0);
    step(0, 0, 0, 0);
    step(0, 1, 1, 1);
    step(0, 0, 0, 0);
    $display("direction modes done");
    cfg(`MODE_PULSE_STOP, `TRIG_LEVEL);
    step(1, 0, 0, 0);
    chk("keys", panel_keys_enable, 0);
    step(1, 1, 0, 0);
    step(0, 1, 0, 0);
    step(1, 1, 1, 0);
    step(0, 1, 1, 0);
    step(0, 0, 0, 0);
    axr(`OFS_STATUS);
    chk("inhib", d[`STS_KEYS_BIT], 1);
    $display("pulse start done");
    cfg(`MODE_FWD_REV, `TRIG_LEVEL);
    for (i = 0; i < 24; i = i + 1) begin
      seed = xs(seed);
      e = exp3(seed[4], seed[5]);
      step(seed[4], seed[5], e[1], e[0]);
    end
    $display("random level done");
    wrap_up;
  end
endmodule

// file: tb/status_source.sv
// status input source model feeding the decoder
`timescale 1ns/100ps
module status_source (
  input wire sys_clk,
  input wire [5:0] level_req,
  output reg [5:0] status_in
);
  initial status_in = 6'h00;
  // contacts change just after an edge, never mid-cycle
  always @(posedge sys_clk) begin
    status_in <= level_req;
  end
endmodule
